/* core/led_engine_pkg.sv */
package led_engine_pkg;
  typedef enum logic [1:0] {SEL_A, SEL_B, SEL_C, SEL_D} var_sel_t;
  typedef enum logic [1:0] {OP_NONE, OP_RAMP, OP_SET, OP_LD} op_t;
  typedef enum {ST_IDLE, ST_RUN} exec_state_t;
endpackage

/* core/led_engine_ramp_wait_exec.sv */
// How it works
// - ramp starts at current duty, one unit/step
// - step timing from bit 14 and 13:9
// - prescale 0 divides by 16, 1 by 512
// - sign zero counts up, one down
// - step lasts step time times prescale cycle
// - increment count sets number of steps
// - saturate at 0/255, keep stepping out
// - zero increments acts as one-step wait
// - variable operands captured at start only
// - selector picks A, B, C or D
// - only five low bits used for step time
// - D host-writable, or test result source
// - variable A and D readable over bus
// - log enable bit per output control
// - duty load is immediate, sixteen cycles
// - duty load may take a variable
// - wait freezes outputs, shows wait status
// - wait time is time field times prescale
// - new mapping gets duty only on push
`timescale 1ns/1ps
`include "led_engine_regs.svh"

module led_engine_ramp_wait_exec #(
  parameter int NUM_LEDS = 9
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic                    master_tick,
  input  wire logic                    instr_valid,
  input  wire logic [15:0]             instr,
  input  wire logic [NUM_LEDS-1:0]     led_map,
  input  wire logic                    var_d_from_adc,
  input  wire logic [7:0]              adc_result,
  input  wire logic [7:0]              reg_addr,
  input  wire logic                    reg_wr,
  input  wire logic [7:0]              reg_wdata,
  output logic [7:0]                   reg_rdata,
  output logic                         busy,
  output logic                         wait_status,
  output logic                         pc_advance,
  output logic                         pwm_push,
  output logic [7:0]                   duty,
  output logic [NUM_LEDS*8-1:0]        led_outputs,
  output logic [NUM_LEDS-1:0]          led_log_en
);
  import led_engine_pkg::*;

  exec_state_t state;
  logic [7:0]  var_a;
  logic [7:0]  var_b;
  logic [7:0]  var_c;
  logic [7:0]  var_d;
  logic [7:0]  ctrl [3];
  logic        prescale_q;
  logic [4:0]  step_q;
  logic        sign_q;
  logic        is_ramp;
  logic [7:0]  inc_left;
  logic [8:0]  div_cnt;
  logic [4:0]  step_cnt;
  op_t         op;
  logic        start;
  logic [7:0]  d_value;
  logic [7:0]  ld_val;
  logic [8:0]  div_last;
  logic        cycle_end;
  logic        step_end;
  logic        last_step;
  logic [7:0]  next_duty;
  logic        next_push;
  logic        start_wait;

  function automatic logic [7:0] pick_var(input logic [1:0] sel, input logic [7:0] a,
                                          input logic [7:0] b, input logic [7:0] c,
                                          input logic [7:0] d);
    case (var_sel_t'(sel))
      SEL_A:   pick_var = a;
      SEL_B:   pick_var = b;
      SEL_C:   pick_var = c;
      default: pick_var = d;
    endcase
  endfunction

  // the immediate duty load form is checked before the numeric ramp, whose encoding overlaps it
  function automatic op_t decode(input logic [15:0] w);
    if (w[15:8] == 8'h40)
      decode = OP_SET;
    else if (w[15] == 1'b0)
      decode = OP_RAMP;
    else if (w[15:10] == 6'b100001 && w[7:4] == 4'h6 && w[3:2] == 2'b00)
      decode = OP_SET;
    else if (w[15:10] == 6'b100001 && w[7:4] == 4'h0)
      decode = OP_RAMP;
    else if (w[15:12] == 4'b1001 && w[9:8] == 2'b00)
      decode = OP_LD;
    else
      decode = OP_NONE;
  endfunction

  // D comes from the host register or from the test result
  assign d_value = var_d_from_adc ? adc_result : var_d;
  assign op      = decode(instr);
  assign start   = instr_valid && !busy && op != OP_NONE;
  assign ld_val  = instr[15] ? pick_var(instr[1:0], var_a, var_b, var_c, d_value)
                             : instr[7:0];

  // a zero count read from a variable must raise wait status as early as an immediate one
  assign start_wait = start && op == OP_RAMP &&
                      (instr[15] ? pick_var(instr[1:0], var_a, var_b, var_c, d_value) : instr[7:0]) == 8'd0;

  // register port
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      var_d   <= `VAR_D_RESET;
      ctrl[0] <= `CTRL_RESET;
      ctrl[1] <= `CTRL_RESET;
      ctrl[2] <= `CTRL_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        `VAR_D_ADDR:    var_d   <= reg_wdata;
        `CTRL_LED1_ADDR: ctrl[0] <= reg_wdata;
        `CTRL_LED2_ADDR: ctrl[1] <= reg_wdata;
        `CTRL_LED3_ADDR: ctrl[2] <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        `VAR_D_ADDR:      reg_rdata <= var_d;
        `VAR_A_ADDR:      reg_rdata <= var_a;
        `ADC_RESULT_ADDR: reg_rdata <= adc_result;
        `CTRL_LED1_ADDR:  reg_rdata <= ctrl[0];
        `CTRL_LED2_ADDR:  reg_rdata <= ctrl[1];
        `CTRL_LED3_ADDR:  reg_rdata <= ctrl[2];
        default:          reg_rdata <= 8'h00;
      endcase
    end
  end

  // three control registers each serve three outputs; shaping itself lives in the driver
  generate
    for (genvar i = 0; i < NUM_LEDS; i++) begin : g_log
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          led_log_en[i] <= 1'b0;
        end else begin
          led_log_en[i] <= ctrl[(i / 3) % 3][`LOG_EN_BIT];
        end
      end
    end
  endgenerate

  // variable load: B and C are not visible on the bus
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      var_a <= 8'h00;
      var_b <= 8'h00;
      var_c <= 8'h00;
    end else if (start && op == OP_LD) begin
      case (var_sel_t'(instr[11:10]))
        SEL_A:   var_a <= instr[7:0];
        SEL_B:   var_b <= instr[7:0];
        SEL_C:   var_c <= instr[7:0];
        default: ;
      endcase
    end
  end

  // timing: master ticks per prescale cycle, cycles per step
  // the last count of the slow divider needs all nine bits, the divisor itself does not fit
  assign div_last  = 9'(prescale_q ? `DIV_SLOW - 10'd1 : `DIV_FAST - 10'd1);
  // a step time of zero wraps round to 32 cycles; software keeps it at 1 to 31
  assign cycle_end = state == ST_RUN && master_tick && div_cnt == div_last;
  assign step_end  = cycle_end && step_cnt == step_q - 5'd1;
  assign last_step = inc_left <= 8'd1;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state      <= ST_IDLE;
      busy       <= 1'b0;
      prescale_q <= 1'b0;
      step_q     <= 5'd1;
      sign_q     <= 1'b0;
      is_ramp    <= 1'b0;
      inc_left   <= 8'd0;
      div_cnt    <= 9'd0;
      step_cnt   <= 5'd0;
    end else begin
      case (state)
        ST_IDLE: begin
          div_cnt  <= 9'd0;
          step_cnt <= 5'd0;
          if (start && op == OP_RAMP) begin
            state      <= ST_RUN;
            busy       <= 1'b1;
            is_ramp    <= 1'b1;
            sign_q     <= instr[`SIGN_BIT];
            if (instr[15]) begin
              // operands frozen here; later variable writes do not reach the ramp
              prescale_q <= instr[9];
              // upper three bits of the variable are dropped on purpose
              step_q     <= 5'(pick_var(instr[3:2], var_a, var_b, var_c, d_value));
              inc_left   <= pick_var(instr[1:0], var_a, var_b, var_c, d_value);
            end else begin
              prescale_q <= instr[`PRESCALE_BIT];
              step_q     <= instr[`STEP_HI:`STEP_LO];
              inc_left   <= instr[7:0];
            end
          end else if (start && op == OP_SET) begin
            state      <= ST_RUN;
            busy       <= 1'b1;
            is_ramp    <= 1'b0;
            prescale_q <= 1'b0;
            step_q     <= `SET_PWM_STEPS;
            inc_left   <= 8'd0;
          end
        end
        ST_RUN: begin
          if (master_tick) begin
            div_cnt <= cycle_end ? 9'd0 : div_cnt + 9'd1;
          end
          if (cycle_end) begin
            step_cnt <= step_end ? 5'd0 : step_cnt + 5'd1;
          end
          if (step_end) begin
            if (last_step) begin
              state <= ST_IDLE;
              busy  <= 1'b0;
            end else begin
              inc_left <= inc_left - 8'd1;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // duty update, saturating; steps still run out after a limit is hit
  always_comb begin
    next_duty = duty;
    next_push = 1'b0;
    if (start && op == OP_SET) begin
      next_duty = ld_val;
      next_push = 1'b1;
    end else if (step_end && is_ramp && inc_left != 8'd0) begin
      next_push = 1'b1;
      if (!sign_q && duty != 8'hff)
        next_duty = duty + 8'd1;
      else if (sign_q && duty != 8'h00)
        next_duty = duty - 8'd1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      duty     <= 8'h00;
      pwm_push <= 1'b0;
    end else begin
      duty     <= next_duty;
      pwm_push <= next_push;
    end
  end

  // ld finishes in its taking cycle, so it advances without ever raising busy
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pc_advance <= 1'b0;
    end else begin
      pc_advance <= (step_end && last_step) || (start && op == OP_LD);
    end
  end

  // a zero-count ramp holds the outputs frozen for its one step
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wait_status <= 1'b0;
    end else begin
      wait_status <= (state == ST_RUN && is_ramp && inc_left == 8'd0 && !(step_end && last_step)) ||
                     start_wait;
    end
  end

  // only mapped outputs take the value, and only on a push
  generate
    for (genvar i = 0; i < NUM_LEDS; i++) begin : g_out
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          led_outputs[i*8 +: 8] <= 8'h00;
        end else if (next_push && led_map[i]) begin
          led_outputs[i*8 +: 8] <= next_duty;
        end
      end
    end
  endgenerate

endmodule // led_engine_ramp_wait_exec

/* core/led_engine_regs.svh */
`ifndef LED_ENGINE_REGS_SVH
`define LED_ENGINE_REGS_SVH
// register offsets on the serial-bus register port
`define CTRL_LED1_ADDR   8'h06
`define CTRL_LED2_ADDR   8'h07
`define CTRL_LED3_ADDR   8'h08
`define VAR_D_ADDR       8'h3c
`define VAR_A_ADDR       8'h3d
`define ADC_RESULT_ADDR  8'h42
`define LOG_EN_BIT       5
`define VAR_D_RESET      8'h00
`define CTRL_RESET       8'h00
// ramp / wait word fields
`define PRESCALE_BIT     14
`define STEP_HI          13
`define STEP_LO          9
`define SIGN_BIT         8
// master clock division per prescale setting
`define DIV_FAST         10'd16
`define DIV_SLOW         10'd512
`define SET_PWM_STEPS    5'd1
`endif

/* sim/led_engine_partner.sv */
`timescale 1ns/1ps
module led_engine_partner #(parameter int TICK_DIV = 4) (
  input wire logic    sys_clk,
  input wire logic    rst,
  output logic        master_tick,
  output logic        instr_valid,
  output logic [15:0] instr
);
  int cnt;
  // fast ticks stand in for the master clock so slow prescale stays affordable
  always_ff @(posedge sys_clk) cnt <= (rst || master_tick) ? 0 : cnt + 1;
  assign master_tick = !rst && cnt == TICK_DIV - 1;
  initial instr_valid = 1'b0;
  initial instr = 16'h0000;
  // offered only while idle, so one edge takes it; the word is scrambled once withdrawn
  task automatic issue(input logic [15:0] w);
    @(posedge sys_clk) #1;
    instr_valid = 1'b1;
    instr = w;
    @(posedge sys_clk) #1;
    instr_valid = 1'b0;
    instr = ~w;
  endtask
endmodule // led_engine_partner

/* sim/led_engine_ramp_wait_exec_sva.sv */
`timescale 1ns/1ps
module led_engine_ramp_wait_exec_sva #(parameter int NUM_LEDS = 9) (
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire logic                  instr_valid,
  input wire logic [15:0]           instr,
  input wire logic [7:0]            reg_addr,
  input wire logic [7:0]            adc_result,
  input wire logic [7:0]            reg_rdata,
  input wire logic                  busy,
  input wire logic                  wait_status,
  input wire logic                  pc_advance,
  input wire logic                  pwm_push,
  input wire logic [7:0]            duty,
  input wire logic [NUM_LEDS*8-1:0] led_outputs
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_take_set;
    instr_valid && !busy && instr[15:8] == 8'h40;
  endsequence
  a_set_load: assert property (s_take_set |=> pwm_push && duty == $past(instr[7:0]))
    else $error("duty load missed");
  a_set_holds: assert property (s_take_set |=> busy [*8]) else $error("duty load too short");
  a_wait_frozen: assert property (wait_status && $past(wait_status) |-> $stable(duty) && !pwm_push)
    else $error("duty moved in wait");
  a_wait_busy: assert property (wait_status |-> busy) else $error("wait without busy");
  a_led_on_push: assert property (!$stable(led_outputs) |-> pwm_push) else $error("outputs moved");
  // a saturated step repeats the limit instead of wrapping round
  a_ramp_unit: assert property (pwm_push && $past(busy) |-> 8'(duty - $past(duty)) inside {8'h01, 8'hff}
    || duty == $past(duty) && duty inside {8'h00, 8'hff}) else $error("ramp step not one unit");
  a_end_advance: assert property ($fell(busy) |-> pc_advance) else $error("no advance at end");
  a_adc_read: assert property ($past(reg_addr) == 8'h42 |-> reg_rdata == $past(adc_result))
    else $error("test result read wrong");
endmodule // led_engine_ramp_wait_exec_sva
bind led_engine_ramp_wait_exec led_engine_ramp_wait_exec_sva #(.NUM_LEDS(NUM_LEDS)) chk_inst (
  .sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid), .instr(instr), .reg_addr(reg_addr),
  .adc_result(adc_result), .reg_rdata(reg_rdata), .busy(busy), .wait_status(wait_status),
  .pc_advance(pc_advance), .pwm_push(pwm_push), .duty(duty), .led_outputs(led_outputs));

/* sim/led_engine_ramp_wait_exec_tb.sv */
`timescale 1ns/1ps
`include "led_engine_regs.svh"
module led_engine_ramp_wait_exec_tb;
  logic        sys_clk = 0, rst = 1, var_d_from_adc = 0, reg_wr = 0, master_tick, instr_valid, busy;
  logic        wait_status, pc_advance, pwm_push;
  logic [8:0]  led_map = 0, led_log_en;
  logic [7:0]  adc_result = 0, reg_addr = 0, reg_wdata = 0, reg_rdata, duty;
  logic [15:0] instr;
  logic [71:0] led_outputs;
  int          fail_count = 0, cmp_count = 0, cycles = 0, pushes, ticks, waited, seed = 32'hd677, d_exp = 0, advs;
  int          led_exp [9] = '{default: 0};
  initial forever #10 sys_clk = ~sys_clk;
  led_engine_partner led_engine_partner_inst (.sys_clk(sys_clk), .rst(rst), .master_tick(master_tick),
    .instr_valid(instr_valid), .instr(instr));
  led_engine_ramp_wait_exec led_engine_ramp_wait_exec_inst (.sys_clk(sys_clk), .rst(rst), .master_tick(master_tick),
    .instr_valid(instr_valid), .instr(instr), .led_map(led_map), .var_d_from_adc(var_d_from_adc),
    .adc_result(adc_result), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .busy(busy), .wait_status(wait_status), .pc_advance(pc_advance), .pwm_push(pwm_push), .duty(duty),
    .led_outputs(led_outputs), .led_log_en(led_log_en));
  always @(posedge sys_clk) begin
    ticks += busy && master_tick;
    pushes += pwm_push;
    advs += pc_advance;
    waited |= wait_status;
    // the whole sequence needs about 4000 cycles
    if (++cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, exp, input int tol);
    cmp_count++;
    if (tol == 0 ? got !== exp : got + tol < exp || got > exp + tol) begin
      fail_count++;
      $display("[FAIL] %0t got %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic reg_io(input logic [7:0] a, input bit wr, input logic [7:0] d);
    @(posedge sys_clk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = wr;
    @(posedge sys_clk) #1;
    reg_wr = 0;
    if (!wr) check(reg_rdata, d, 0);
  endtask
  task automatic run(input logic [15:0] w, input int n, t);
    pushes = 0;
    ticks = 0;
    waited = 0;
    advs = 0;
    led_map = 9'($random(seed));
    led_engine_partner_inst.issue(w);
    for (int k = 0; busy !== 1'b0 && k < 9000; k++) @(posedge sys_clk) #1;
    @(posedge sys_clk) #1;
    for (int k = 0; k < 9; k++) begin
      if (led_map[k] && n > 0) led_exp[k] = d_exp;
      check(led_outputs[k*8+:8], led_exp[k], 0);
    end
    check(duty, d_exp, 0);
    check(pushes, n, 0);
    check(ticks, t, 1);
    check(waited, n == 0, 0);
    check(advs, 1, 0);
    check(busy, 1'b0, 0);
  endtask
  task automatic ramp(input logic [15:0] w, input bit p, s, input int st, n);
    repeat (n) d_exp = s ? (d_exp > 0 ? d_exp - 1 : 0) : (d_exp < 255 ? d_exp + 1 : 255);
    run(w ? w : {1'b0, p, 5'(st), s, 8'(n)}, n, st * (p ? 512 : 16) * (n > 0 ? n : 1));
  endtask
  task automatic setp(input logic [15:0] w, input int v);
    d_exp = v;
    run(w, 1, 16);
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    #1;
    rst = 0;
    reg_io(`VAR_D_ADDR, 0, `VAR_D_RESET);
    setp(16'h40aa, 'haa);
    ramp(0, 0, 0, 2, 3);
    setp(16'h40fe, 'hfe);
    ramp(0, 0, 0, 1, 4);
    ramp(0, 0, 1, 3, 0);
    ramp(0, 1, 1, 1, 1);
    advs = 0;
    led_engine_partner_inst.issue(16'h9022);
    led_engine_partner_inst.issue(16'h9403);
    led_engine_partner_inst.issue(16'h9877);
    reg_io(`VAR_A_ADDR, 0, 8'h22);
    check(advs, 3, 0);
    ramp(16'h8401, 0, 0, 2, 3);
    reg_io(`VAR_D_ADDR, 1, 8'h02);
    fork
      ramp(16'h8503, 0, 1, 2, 2);
      #600 reg_io(`VAR_D_ADDR, 1, 8'h50);
    join
    setp(16'h8463, 'h50);
    setp(16'h8462, 'h77);
    adc_result = 8'($random(seed));
    var_d_from_adc = 1;
    setp(16'h8463, adc_result);
    reg_io(`ADC_RESULT_ADDR, 1, 8'h00);
    reg_io(`ADC_RESULT_ADDR, 0, adc_result);
    reg_io(8'h50, 0, 8'h00);
    reg_io(`CTRL_LED3_ADDR, 1, 8'h20);
    reg_io(`CTRL_LED3_ADDR, 0, 8'h20);
    check(led_log_en, 9'h1c0, 0);
    tally_and_finish();
  end
endmodule // led_engine_ramp_wait_exec_tb
